// ===== design/hwbrk_channels.sv
`timescale 1ns/1ps
// What this block does
// - control bit 23 adds space-id compare
// - control bit 6 reads preset range support
// - bit 5 picks inside/outside range
// - bit 4 picks mask-equality or range match
// - bit 2 makes match a triggerpoint
// - bit 0 makes match a breakpoint
// - reserved bits except data control bit 1 read zero, writes ignored
// - complex bits 13:12 read zero
// - arm code 11:10, 00 bypasses arming
// - complex bit 9 lets channel arm others
// - bits 8:5 read partner data channel
// - complex bit 4 needs partner data hit
// - 8-bit instruction, 16-bit data skip counter counts matches to zero
// - nonzero skip load marks actions imprecise
// - data registers at base plus 0x100 per channel
// - status 27:24 reports that status register's channel count, 8 instruction or 4 data
// - status bit 30 reports space-id support
// - data hit flags set by match, cleared writing zero
// - mask bit one drops address bit from compare
// - data space-id is eight bits, rest zero
// - data control bit 23 adds space-id compare
// - instruction hit only when break or trigger enabled
// - enabled data break raises debug exception
module hwbrk_channels (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire hwbrk_pkg::hwbrk_reg_req_t reg_req,
	output logic [31:0] reg_rdata,
	output logic reg_ack,
	input wire hwbrk_pkg::hwbrk_fetch_t fetch,
	input wire hwbrk_pkg::hwbrk_access_t access,
	output logic debug_exc,
	output logic trigger_out,
	output logic action_imprecise
);
	import hwbrk_pkg::*;

	logic [31:0] ib_addr_r [NUM_IB];
	logic [31:0] ib_mask_r [NUM_IB];
	logic [7:0] ib_space_r [NUM_IB];
	logic [31:0] ib_ctrl_r [NUM_IB];
	logic [31:0] ib_cc_r [NUM_IB];
	logic [IB_SKIP_W-1:0] ib_skip_r [NUM_IB];
	logic [NUM_IB-1:0] ib_hit_r;
	logic [NUM_IB-1:0] ib_imprecise_r;
	logic [31:0] db_addr_r [NUM_DB];
	logic [31:0] db_mask_r [NUM_DB];
	logic [7:0] db_space_r [NUM_DB];
	logic [31:0] db_ctrl_r [NUM_DB];
	logic [31:0] db_value_r [NUM_DB];
	logic [31:0] db_cc_r [NUM_DB];
	logic [DB_SKIP_W-1:0] db_skip_r [NUM_DB];
	logic [NUM_DB-1:0] db_hit_r;
	logic [NUM_DB-1:0] db_imprecise_r;
	logic [31:0] load_capture_r;
	logic [NUM_IB-1:0] ib_armed_r;
	logic [NUM_DB-1:0] db_armed_r;

	logic [NUM_IB-1:0] ib_raw;
	logic [NUM_IB-1:0] ib_fire;
	logic [NUM_IB-1:0] ib_count;
	logic [NUM_DB-1:0] db_raw;
	logic [NUM_DB-1:0] db_fire;
	logic [NUM_DB-1:0] db_count;
	logic [NUM_DB-1:0] db_precise_fire;
	logic [31:0] rdata_nxt;

	// equality-with-mask or range compare, optionally excluding the range
	function automatic logic addr_match(input logic [31:0] a, input logic [31:0] base,
			input logic [31:0] mask, input logic use_range, input logic excl);
		logic in_range;
		logic hit;
		in_range = (a & ~mask) == (base & ~mask);
		if (use_range) begin
			hit = in_range ^ excl;
		end else begin
			hit = in_range;
		end
		return hit;
	endfunction

	function automatic logic [1:0] partner_of(input int n);
		return 2'(n / 2);
	endfunction

	// arming source: code 1 picks the partner data channel, 2 the next and 3 the previous instruction channel
	function automatic logic armed_ok(input logic [1:0] code, input logic [NUM_IB-1:0] ib_src,
			input logic [NUM_DB-1:0] db_src, input int n);
		logic ok;
		case (code)
			2'h0: ok = 1'b1;
			2'h1: ok = db_src[partner_of(n)];
			2'h2: ok = ib_src[(n + 1) % NUM_IB];
			default: ok = ib_src[(n + NUM_IB - 1) % NUM_IB];
		endcase
		return ok;
	endfunction

	function automatic logic is_wr(input hwbrk_reg_req_t q, input logic [15:0] ofs, input int n);
		return q.wr && q.addr == 16'(ofs + 16'(n) * CH_STRIDE);
	endfunction

	// chain sources: channels flagged for chaining that matched
	logic [NUM_IB-1:0] ib_chain_src;
	logic [NUM_DB-1:0] db_chain_src;

	always_comb begin
		for (int n = 0; n < NUM_DB; n++) begin
			db_raw[n] = access.valid
				&& addr_match(access.addr, db_addr_r[n], db_mask_r[n], 1'b0, 1'b0)
				&& (!db_ctrl_r[n][CTL_SPACE_USE] || access.space_id == db_space_r[n]);
			db_chain_src[n] = db_raw[n] && db_cc_r[n][CC_CHAIN];
			db_count[n] = db_raw[n] && (db_ctrl_r[n][CTL_BRK] || db_ctrl_r[n][CTL_TRIG])
				&& armed_ok(db_cc_r[n][CC_ARM_HI:CC_ARM_LO], ib_armed_r, db_armed_r, n);
			db_fire[n] = db_count[n] && db_skip_r[n] == '0;
			// only precise firings may overwrite the captured load value
			db_precise_fire[n] = db_fire[n] && !db_imprecise_r[n];
		end
		for (int n = 0; n < NUM_IB; n++) begin
			ib_raw[n] = fetch.valid
				&& addr_match(fetch.addr, ib_addr_r[n], ib_mask_r[n], ib_ctrl_r[n][CTL_RANGE],
					ib_ctrl_r[n][CTL_EXCL])
				&& (!ib_ctrl_r[n][CTL_SPACE_USE] || fetch.space_id == ib_space_r[n]);
			ib_chain_src[n] = ib_raw[n] && ib_cc_r[n][CC_CHAIN];
			ib_count[n] = ib_raw[n] && (ib_ctrl_r[n][CTL_BRK] || ib_ctrl_r[n][CTL_TRIG])
				&& (!ib_cc_r[n][CC_QUAL] || db_raw[partner_of(n)])
				&& armed_ok(ib_cc_r[n][CC_ARM_HI:CC_ARM_LO], ib_armed_r, db_armed_r, n);
			ib_fire[n] = ib_count[n] && ib_skip_r[n] == '0;
		end
	end

	// arming is sticky once the source has matched; cleared by reset only
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ib_armed_r <= '0;
		end else begin
			ib_armed_r <= ib_armed_r | ib_chain_src;
		end
	end

	// data arming kept apart so each source set has its own process
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			db_armed_r <= '0;
		end else begin
			db_armed_r <= db_armed_r | db_chain_src;
		end
	end

	// instruction channel registers
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			for (int n = 0; n < NUM_IB; n++) begin
				ib_addr_r[n] <= '0;
				ib_mask_r[n] <= '0;
				ib_space_r[n] <= '0;
				ib_ctrl_r[n] <= '0;
				ib_cc_r[n] <= '0;
				ib_skip_r[n] <= '0;
			end
			ib_imprecise_r <= '0;
		end else begin
			for (int n = 0; n < NUM_IB; n++) begin
				if (is_wr(reg_req, IB_ADDR_OFS, n)) begin
					ib_addr_r[n] <= reg_req.wdata;
				end
				if (is_wr(reg_req, IB_MASK_OFS, n)) begin
					ib_mask_r[n] <= reg_req.wdata;
				end
				if (is_wr(reg_req, IB_SPACE_OFS, n)) begin
					ib_space_r[n] <= reg_req.wdata[7:0];
				end
				if (is_wr(reg_req, IB_CTRL_OFS, n)) begin
					ib_ctrl_r[n] <= reg_req.wdata & IB_CTRL_WMASK;
				end
				if (is_wr(reg_req, IB_CCTRL_OFS, n)) begin
					ib_cc_r[n] <= '0;
					ib_cc_r[n][CC_ARM_HI:CC_ARM_LO] <= reg_req.wdata[CC_ARM_HI:CC_ARM_LO];
					ib_cc_r[n][CC_CHAIN] <= reg_req.wdata[CC_CHAIN];
					ib_cc_r[n][CC_QUAL] <= reg_req.wdata[CC_QUAL];
				end
				// a software write wins over a same-cycle decrement
				if (is_wr(reg_req, IB_SKIP_OFS, n)) begin
					ib_skip_r[n] <= reg_req.wdata[IB_SKIP_W-1:0];
					ib_imprecise_r[n] <= reg_req.wdata[IB_SKIP_W-1:0] != '0;
				end else if (ib_count[n] && ib_skip_r[n] != '0) begin
					ib_skip_r[n] <= ib_skip_r[n] - 1'b1;
				end
			end
		end
	end

	// data channel registers
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			for (int n = 0; n < NUM_DB; n++) begin
				db_addr_r[n] <= '0;
				db_mask_r[n] <= '0;
				db_space_r[n] <= '0;
				db_ctrl_r[n] <= '0;
				db_value_r[n] <= '0;
				db_cc_r[n] <= '0;
				db_skip_r[n] <= '0;
			end
			db_imprecise_r <= '0;
		end else begin
			for (int n = 0; n < NUM_DB; n++) begin
				if (is_wr(reg_req, DB_ADDR_OFS, n)) begin
					db_addr_r[n] <= reg_req.wdata;
				end
				if (is_wr(reg_req, DB_MASK_OFS, n)) begin
					db_mask_r[n] <= reg_req.wdata;
				end
				if (is_wr(reg_req, DB_SPACE_OFS, n)) begin
					db_space_r[n] <= reg_req.wdata[7:0];
				end
				if (is_wr(reg_req, DB_CTRL_OFS, n)) begin
					db_ctrl_r[n] <= reg_req.wdata & DB_CTRL_WMASK;
				end
				if (is_wr(reg_req, DB_VALUE_OFS, n)) begin
					db_value_r[n] <= reg_req.wdata;
				end
				if (is_wr(reg_req, DB_CCTRL_OFS, n)) begin
					db_cc_r[n] <= '0;
					db_cc_r[n][CC_ARM_HI:CC_ARM_LO] <= reg_req.wdata[CC_ARM_HI:CC_ARM_LO];
					db_cc_r[n][CC_CHAIN] <= reg_req.wdata[CC_CHAIN];
				end
				if (is_wr(reg_req, DB_SKIP_OFS, n)) begin
					db_skip_r[n] <= reg_req.wdata[DB_SKIP_W-1:0];
					db_imprecise_r[n] <= reg_req.wdata[DB_SKIP_W-1:0] != '0;
				end else if (db_count[n] && db_skip_r[n] != '0) begin
					db_skip_r[n] <= db_skip_r[n] - 1'b1;
				end
			end
		end
	end

	// hit flags: a match in the clearing cycle keeps the flag set
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ib_hit_r <= '0;
		end else if (reg_req.wr && reg_req.addr == IB_STATUS_OFS) begin
			ib_hit_r <= (ib_hit_r & reg_req.wdata[NUM_IB-1:0]) | ib_fire;
		end else begin
			ib_hit_r <= ib_hit_r | ib_fire;
		end
	end

	// writing one to a flag leaves it alone; only zero clears
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			db_hit_r <= '0;
		end else if (reg_req.wr && reg_req.addr == DB_STATUS_OFS) begin
			db_hit_r <= (db_hit_r & reg_req.wdata[NUM_DB-1:0]) | db_fire;
		end else begin
			db_hit_r <= db_hit_r | db_fire;
		end
	end

	// load value seen by a firing data break, for software to replay
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			load_capture_r <= '0;
		end else if (access.is_load && |db_precise_fire) begin
			load_capture_r <= access.data;
		end
	end

	// read mux
	always_comb begin
		rdata_nxt = '0;
		if (reg_req.addr == IB_STATUS_OFS) begin
			rdata_nxt[ST_SPACE_SUP] = 1'b1;
			rdata_nxt[ST_COUNT_LO +: 4] = IB_COUNT;
			rdata_nxt[NUM_IB-1:0] = ib_hit_r;
		end
		if (reg_req.addr == DB_STATUS_OFS) begin
			rdata_nxt[ST_SPACE_SUP] = 1'b1;
			rdata_nxt[ST_COUNT_LO +: 4] = DB_COUNT;
			rdata_nxt[NUM_DB-1:0] = db_hit_r;
		end
		if (reg_req.addr == LOAD_CAPTURE_OFS) begin
			rdata_nxt = load_capture_r;
		end
		for (int n = 0; n < NUM_IB; n++) begin
			if (reg_req.addr == 16'(IB_ADDR_OFS + 16'(n) * CH_STRIDE)) begin
				rdata_nxt = ib_addr_r[n];
			end
			if (reg_req.addr == 16'(IB_MASK_OFS + 16'(n) * CH_STRIDE)) begin
				rdata_nxt = ib_mask_r[n];
			end
			if (reg_req.addr == 16'(IB_SPACE_OFS + 16'(n) * CH_STRIDE)) begin
				rdata_nxt = {24'h000000, ib_space_r[n]};
			end
			if (reg_req.addr == 16'(IB_CTRL_OFS + 16'(n) * CH_STRIDE)) begin
				rdata_nxt = ib_ctrl_r[n] | RANGE_SUP_PRESET;
			end
			if (reg_req.addr == 16'(IB_CCTRL_OFS + 16'(n) * CH_STRIDE)) begin
				rdata_nxt = ib_cc_r[n];
				rdata_nxt[CC_PARTNER_LO +: 4] = {2'b00, partner_of(n)};
			end
			if (reg_req.addr == 16'(IB_SKIP_OFS + 16'(n) * CH_STRIDE)) begin
				rdata_nxt = {24'h000000, ib_skip_r[n]};
			end
		end
		for (int n = 0; n < NUM_DB; n++) begin
			if (reg_req.addr == 16'(DB_ADDR_OFS + 16'(n) * CH_STRIDE)) begin
				rdata_nxt = db_addr_r[n];
			end
			if (reg_req.addr == 16'(DB_MASK_OFS + 16'(n) * CH_STRIDE)) begin
				rdata_nxt = db_mask_r[n];
			end
			if (reg_req.addr == 16'(DB_SPACE_OFS + 16'(n) * CH_STRIDE)) begin
				rdata_nxt = {24'h000000, db_space_r[n]};
			end
			if (reg_req.addr == 16'(DB_CTRL_OFS + 16'(n) * CH_STRIDE)) begin
				rdata_nxt = db_ctrl_r[n];
			end
			// value register is stored only; no value compare is built
			if (reg_req.addr == 16'(DB_VALUE_OFS + 16'(n) * CH_STRIDE)) begin
				rdata_nxt = db_value_r[n];
			end
			if (reg_req.addr == 16'(DB_CCTRL_OFS + 16'(n) * CH_STRIDE)) begin
				rdata_nxt = db_cc_r[n];
			end
			if (reg_req.addr == 16'(DB_SKIP_OFS + 16'(n) * CH_STRIDE)) begin
				rdata_nxt = {16'h0000, db_skip_r[n]};
			end
		end
	end

	// outputs registered; actions appear one cycle after the match
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= '0;
			reg_ack <= 1'b0;
			debug_exc <= 1'b0;
			trigger_out <= 1'b0;
			action_imprecise <= 1'b0;
		end else begin
			reg_rdata <= reg_req.rd ? rdata_nxt : '0;
			reg_ack <= reg_req.rd || reg_req.wr;
			debug_exc <= |(ib_fire & brk_bits_ib()) || |(db_fire & brk_bits_db());
			trigger_out <= |(ib_fire & trg_bits_ib()) || |(db_fire & trg_bits_db());
			action_imprecise <= |(ib_fire & ib_imprecise_r) || |(db_fire & db_imprecise_r);
		end
	end

	// gather the per-channel enable bits into vectors for the action or
	function automatic logic [NUM_IB-1:0] brk_bits_ib();
		for (int n = 0; n < NUM_IB; n++) begin
			brk_bits_ib[n] = ib_ctrl_r[n][CTL_BRK];
		end
	endfunction
	function automatic logic [NUM_IB-1:0] trg_bits_ib();
		for (int n = 0; n < NUM_IB; n++) begin
			trg_bits_ib[n] = ib_ctrl_r[n][CTL_TRIG];
		end
	endfunction
	function automatic logic [NUM_DB-1:0] brk_bits_db();
		for (int n = 0; n < NUM_DB; n++) begin
			brk_bits_db[n] = db_ctrl_r[n][CTL_BRK];
		end
	endfunction
	function automatic logic [NUM_DB-1:0] trg_bits_db();
		for (int n = 0; n < NUM_DB; n++) begin
			trg_bits_db[n] = db_ctrl_r[n][CTL_TRIG];
		end
	endfunction
endmodule

// ===== common/hwbrk_pkg.sv
package hwbrk_pkg;
	localparam int NUM_IB = 8;
	localparam int NUM_DB = 4;
	// drseg offsets, per-channel stride 0x100
	localparam logic [15:0] CH_STRIDE = 16'h0100;
	localparam logic [15:0] IB_BASE = 16'h1100;
	localparam logic [15:0] IB_ADDR_OFS = 16'h1100;
	localparam logic [15:0] IB_MASK_OFS = 16'h1108;
	localparam logic [15:0] IB_SPACE_OFS = 16'h1110;
	localparam logic [15:0] IB_CTRL_OFS = 16'h1118;
	localparam logic [15:0] IB_CCTRL_OFS = 16'h1120;
	localparam logic [15:0] IB_SKIP_OFS = 16'h1128;
	localparam logic [15:0] IB_STATUS_OFS = 16'h1000;
	localparam logic [15:0] DB_STATUS_OFS = 16'h2000;
	localparam logic [15:0] DB_BASE = 16'h2100;
	localparam logic [15:0] DB_ADDR_OFS = 16'h2100;
	localparam logic [15:0] DB_MASK_OFS = 16'h2108;
	localparam logic [15:0] DB_SPACE_OFS = 16'h2110;
	localparam logic [15:0] DB_CTRL_OFS = 16'h2118;
	localparam logic [15:0] DB_VALUE_OFS = 16'h2120;
	localparam logic [15:0] DB_CCTRL_OFS = 16'h2128;
	localparam logic [15:0] DB_SKIP_OFS = 16'h2130;
	localparam logic [15:0] LOAD_CAPTURE_OFS = 16'h2FF0;
	// control field positions
	localparam int CTL_SPACE_USE = 23;
	localparam int CTL_RANGE_SUP = 6;
	localparam int CTL_EXCL = 5;
	localparam int CTL_RANGE = 4;
	localparam int CTL_TRIG = 2;
	localparam int CTL_BRK = 0;
	localparam logic [31:0] IB_CTRL_WMASK = 32'h0080_0035;
	localparam logic [31:0] DB_CTRL_WMASK = 32'h0080_0007;
	localparam int CC_ARM_HI = 11;
	localparam int CC_ARM_LO = 10;
	localparam int CC_CHAIN = 9;
	localparam int CC_PARTNER_LO = 5;
	localparam int CC_QUAL = 4;
	localparam int ST_SPACE_SUP = 30;
	localparam int ST_COUNT_LO = 24;
	localparam logic [3:0] IB_COUNT = 4'h8;
	localparam logic [3:0] DB_COUNT = 4'h4;
	localparam logic [31:0] RANGE_SUP_PRESET = 32'h0000_0040;
	localparam int IB_SKIP_W = 8;
	localparam int DB_SKIP_W = 16;

	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic [7:0] space_id;
	} hwbrk_fetch_t;

	typedef struct packed {
		logic valid;
		logic is_load;
		logic [31:0] addr;
		logic [7:0] space_id;
		logic [31:0] data;
	} hwbrk_access_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [31:0] wdata;
	} hwbrk_reg_req_t;
endpackage

// ===== testbench/hwbrk_channels_props.sv
`timescale 1ns/1ps
module hwbrk_channels_props (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire hwbrk_pkg::hwbrk_reg_req_t reg_req,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_ack,
	input wire hwbrk_pkg::hwbrk_fetch_t fetch,
	input wire hwbrk_pkg::hwbrk_access_t access,
	input wire logic debug_exc,
	input wire logic trigger_out,
	input wire logic action_imprecise
);
	import hwbrk_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	logic ib_rd;
	logic db_rd;
	logic [2:0] ch_sel;
	logic [3:0] pair_num;
	assign ib_rd = reg_req.rd && reg_req.addr[15:12] == 4'h1 && reg_req.addr[11:8] != 4'h0;
	assign db_rd = reg_req.rd && reg_req.addr[15:12] == 4'h2 && reg_req.addr[11:8] != 4'h0;
	assign ch_sel = 3'(reg_req.addr[11:8] - 4'h1);
	assign pair_num = {2'b00, ch_sel[2:1]};
	a_ack_follows_req: assert property ((reg_req.wr || reg_req.rd) |=> reg_ack)
		else $error("register access not acknowledged");
	a_ack_needs_req: assert property (!(reg_req.wr || reg_req.rd) |=> !reg_ack)
		else $error("acknowledge without access");
	a_ctrl_preset_bits: assert property (ib_rd && reg_req.addr[7:0] == 8'h18
		|=> reg_rdata[6] && (reg_rdata & 32'hFF7F_FF8A) == 32'h0)
		else $error("instruction control reserved or preset bits wrong");
	a_partner_num_field: assert property (ib_rd && reg_req.addr[7:0] == 8'h20
		|=> reg_rdata[8:5] == $past(pair_num) && reg_rdata[31:12] == 20'h0)
		else $error("complex control fixed fields wrong");
	a_skip_upper_zero: assert property (ib_rd && reg_req.addr[7:0] == 8'h28
		|=> reg_rdata[31:8] == 24'h0)
		else $error("skip counter upper bits not zero");
	a_status_count_field: assert property (reg_req.rd && reg_req.addr == DB_STATUS_OFS
		|=> reg_rdata[31:24] == 8'h44 && reg_rdata[23:4] == 20'h0)
		else $error("data status fixed fields wrong");
	a_space_id_upper: assert property (db_rd && reg_req.addr[7:0] == 8'h10
		|=> reg_rdata[31:8] == 24'h0)
		else $error("data space id upper bits not zero");
	a_fire_needs_valid: assert property (!(fetch.valid || access.valid)
		|=> !debug_exc && !trigger_out)
		else $error("firing without a compared access");
	a_imprecise_with_fire: assert property (action_imprecise |-> debug_exc || trigger_out)
		else $error("imprecise flag without firing");
endmodule

bind hwbrk_channels hwbrk_channels_props u_props (.clk_sys(clk_sys), .nrst(nrst),
	.reg_req(reg_req), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .fetch(fetch),
	.access(access), .debug_exc(debug_exc), .trigger_out(trigger_out),
	.action_imprecise(action_imprecise));

// ===== testbench/hwbrk_pipe_model.sv
`timescale 1ns/1ps
module hwbrk_pipe_model (
	input wire logic clk_sys,
	output hwbrk_pkg::hwbrk_fetch_t fetch,
	output hwbrk_pkg::hwbrk_access_t access
);
	import hwbrk_pkg::*;
	initial begin
		fetch = '0;
		access = '0;
	end
	// idle lines carry the inverse so a stale compare cannot match by luck
	task automatic fetch_at(input logic [31:0] a, input logic [7:0] s);
		@(negedge clk_sys);
		fetch <= '{1'b1, a, s};
		@(negedge clk_sys);
		fetch <= '{1'b0, ~a, ~s};
	endtask
	task automatic access_at(input logic [31:0] a, input logic [7:0] s);
		@(negedge clk_sys);
		access <= '{1'b1, 1'b1, a, s, ~a};
		@(negedge clk_sys);
		access <= '{1'b0, 1'b0, ~a, ~s, a};
	endtask
endmodule

// ===== testbench/hwbrk_channels_tb_top.sv
`timescale 1ns/1ps
`define CHK(got, ev) begin tests_run++; if ((got) !== (ev)) begin n_mismatch++; $display("unexpected t=%0t got %0h exp %0h", $time, (got), (ev)); end end
module hwbrk_channels_tb_top;
	import hwbrk_pkg::*;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	hwbrk_reg_req_t reg_req = '0;
	hwbrk_fetch_t fetch;
	hwbrk_access_t access;
	logic [31:0] reg_rdata;
	logic reg_ack, debug_exc, trigger_out, action_imprecise, hit0;
	int n_mismatch = 0;
	int tests_run = 0;
	int cycles = 0;
	integer seed = 32'hB1D9;
	logic [31:0] r, a, m;
	localparam logic [31:0] IA = 32'h0000_4000;
	localparam logic [31:0] DA = 32'h8000_0010;
	hwbrk_channels dut (.clk_sys(clk_sys), .nrst(nrst), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .reg_ack(reg_ack), .fetch(fetch), .access(access),
		.debug_exc(debug_exc), .trigger_out(trigger_out), .action_imprecise(action_imprecise));
	hwbrk_pipe_model pipe (.clk_sys(clk_sys), .fetch(fetch), .access(access));
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	function automatic logic [15:0] ofs(input logic [15:0] b, input int n);
		return b + 16'(n) * CH_STRIDE;
	endfunction
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles > 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	task automatic wr(input logic [15:0] ad, input logic [31:0] d);
		@(negedge clk_sys);
		reg_req <= '{1'b1, 1'b0, ad, d};
		@(negedge clk_sys);
		reg_req.wr <= 1'b0;
		`CHK(reg_ack, 1'b1)
	endtask
	task automatic rdc(input logic [15:0] ad, input logic [31:0] ev, input logic [31:0] msk);
		@(negedge clk_sys);
		reg_req <= '{1'b0, 1'b1, ad, 32'h0};
		@(negedge clk_sys);
		reg_req.rd <= 1'b0;
		`CHK(reg_rdata & msk, ev)
	endtask
	task automatic fire(input logic dat, input logic [31:0] ad, input logic [7:0] s,
		input logic eb, input logic et);
		if (dat) begin
			pipe.access_at(ad, s);
		end else begin
			pipe.fetch_at(ad, s);
		end
		`CHK({debug_exc, trigger_out}, {eb, et})
	endtask
	initial begin
		repeat (10) @(posedge clk_sys);
		@(negedge clk_sys);
		nrst = 1'b1;
		for (int n = 0; n < 8; n++) begin
			rdc(ofs(IB_CTRL_OFS, n), 32'h0000_0040, '1);
			rdc(ofs(IB_CCTRL_OFS, n), 32'(n / 2) << 5, '1);
			rdc(ofs(IB_SKIP_OFS, n), 32'h0, '1);
			r = $random(seed);
			wr(ofs(IB_CTRL_OFS, n), r);
			rdc(ofs(IB_CTRL_OFS, n), (r & 32'h0080_0035) | 32'h40, '1);
			wr(ofs(IB_CTRL_OFS, n), 32'h0);
			// skip is loaded and cleared before the chain bit can be set
			wr(ofs(IB_SKIP_OFS, n), r);
			rdc(ofs(IB_SKIP_OFS, n), r & 32'hFF, '1);
			wr(ofs(IB_SKIP_OFS, n), 32'h0);
			wr(ofs(IB_CCTRL_OFS, n), r);
			rdc(ofs(IB_CCTRL_OFS, n), (r & 32'h0E10) | (32'(n / 2) << 5), '1);
			wr(ofs(IB_CCTRL_OFS, n), 32'h0);
		end
		for (int n = 0; n < 4; n++) begin
			r = $random(seed);
			wr(ofs(DB_SPACE_OFS, n), r);
			rdc(ofs(DB_SPACE_OFS, n), r & 32'hFF, '1);
			wr(ofs(DB_MASK_OFS, n), ~r);
			rdc(ofs(DB_MASK_OFS, n), ~r, '1);
		end
		rdc(DB_STATUS_OFS, 32'h4400_0000, '1);
		rdc(16'h3000, 32'h0, '1);
		wr(IB_ADDR_OFS, IA);
		wr(IB_MASK_OFS, 32'h0);
		fire(1'b0, IA, 8'h0, 1'b0, 1'b0);
		rdc(IB_STATUS_OFS, 32'h0, 32'hFF);
		wr(IB_CTRL_OFS, 32'h1);
		fire(1'b0, IA, 8'h0, 1'b1, 1'b0);
		fire(1'b0, IA ^ 32'h4, 8'h0, 1'b0, 1'b0);
		rdc(IB_STATUS_OFS, 32'h1, 32'hFF);
		wr(IB_STATUS_OFS, 32'h0);
		rdc(IB_STATUS_OFS, 32'h0, 32'hFF);
		wr(IB_CTRL_OFS, 32'h4);
		fire(1'b0, IA, 8'h0, 1'b0, 1'b1);
		wr(IB_CTRL_OFS, 32'h0080_0001);
		wr(IB_SPACE_OFS, 32'h5);
		fire(1'b0, IA, 8'h6, 1'b0, 1'b0);
		fire(1'b0, IA, 8'h5, 1'b1, 1'b0);
		wr(IB_CTRL_OFS, 32'h1);
		for (int i = 0; i < 24; i++) begin
			m = $random(seed) & 32'h0000_0011;
			a = IA ^ ($random(seed) & 32'h0000_0011);
			wr(IB_MASK_OFS, m);
			fire(1'b0, a, 8'h0, ((a ^ IA) & ~m) == 32'h0, 1'b0);
		end
		wr(IB_MASK_OFS, '1);
		fire(1'b0, ~IA, 8'h0, 1'b1, 1'b0);
		wr(IB_MASK_OFS, 32'h0000_8000);
		wr(IB_CTRL_OFS, 32'h11);
		pipe.fetch_at(IA, 8'h0);
		hit0 = debug_exc;
		wr(IB_CTRL_OFS, 32'h31);
		pipe.fetch_at(IA, 8'h0);
		`CHK(hit0 ^ debug_exc, 1'b1)
		wr(IB_MASK_OFS, 32'h0);
		wr(IB_CTRL_OFS, 32'h1);
		wr(IB_CCTRL_OFS, 32'h10);
		fire(1'b0, IA, 8'h0, 1'b0, 1'b0);
		wr(IB_CCTRL_OFS, 32'h0);
		wr(IB_SKIP_OFS, 32'h2);
		fire(1'b0, IA, 8'h0, 1'b0, 1'b0);
		fire(1'b0, IA, 8'h0, 1'b0, 1'b0);
		fire(1'b0, IA, 8'h0, 1'b1, 1'b0);
		`CHK(action_imprecise, 1'b1)
		rdc(IB_SKIP_OFS, 32'h0, '1);
		wr(IB_SKIP_OFS, 32'h0);
		fire(1'b0, IA, 8'h0, 1'b1, 1'b0);
		`CHK(action_imprecise, 1'b0)
		wr(IB_CTRL_OFS, 32'h0);
		wr(IB_SKIP_OFS, 32'h1);
		fire(1'b0, IA, 8'h0, 1'b0, 1'b0);
		rdc(IB_SKIP_OFS, 32'h1, '1);
		wr(IB_SKIP_OFS, 32'h0);
		wr(ofs(DB_ADDR_OFS, 1), DA);
		wr(ofs(DB_MASK_OFS, 1), 32'hF);
		wr(ofs(DB_CTRL_OFS, 1), 32'h1);
		fire(1'b1, DA | 32'h3, 8'h0, 1'b1, 1'b0);
		rdc(LOAD_CAPTURE_OFS, ~(DA | 32'h3), '1);
		fire(1'b1, DA ^ 32'h100, 8'h0, 1'b0, 1'b0);
		rdc(DB_STATUS_OFS, 32'h2, 32'hF);
		wr(DB_STATUS_OFS, 32'h0);
		rdc(DB_STATUS_OFS, 32'h0, 32'hF);
		wr(ofs(DB_CTRL_OFS, 1), 32'h0080_0001);
		wr(ofs(DB_SPACE_OFS, 1), 32'h7);
		fire(1'b1, DA, 8'h8, 1'b0, 1'b0);
		fire(1'b1, DA, 8'h7, 1'b1, 1'b0);
		tally_and_finish();
	end
endmodule
